// ===== design/lccr_regs.sv
/*
 lccr_regs: APB register bank for a four-channel line codec: real-time
 line data with interrupt, analog gains, line I/O latch and direction,
 coding and coefficient select, interrupt mask.
 assumes a single 20 MHz clock; line pins come from outside and are
 synchronised here; channel activity, clock failure and multiplexed
 line mode come from logic on the same clock.
*/
// The APB register port was decided locally.
`timescale 1ns/100ps
module lccr_regs (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lccr_pkg::ADDR_W-1:0] paddr,
   input wire logic [lccr_pkg::DATA_W-1:0] pwdata,
   output logic [lccr_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // line interface pins, [channel][pin], pin 0 is line_io_pin_one
   input wire logic [lccr_pkg::NUM_CH-1:0][lccr_pkg::NUM_PINS-1:0]
      line_io_pin_in,
   output logic [lccr_pkg::NUM_CH-1:0][lccr_pkg::NUM_PINS-1:0]
      line_io_pin_out,
   output logic [lccr_pkg::NUM_CH-1:0][lccr_pkg::NUM_PINS-1:0]
      line_io_pin_oe,
   output logic [lccr_pkg::NUM_CH-1:0] secondary_first_pin_out,
   // channel state from the codec core
   input wire logic [lccr_pkg::NUM_CH-1:0] channel_active_in,
   input wire logic clock_sync_fail_in,
   input wire logic [lccr_pkg::NUM_CH-1:0] multiplexed_line_mode_enable,
   // per-channel settings to the datapaths
   output logic [lccr_pkg::NUM_CH-1:0][lccr_pkg::BYTE_W-1:0] gain_cfg,
   output logic [lccr_pkg::NUM_CH-1:0] full_loopback,
   output logic [lccr_pkg::NUM_CH-1:0][lccr_pkg::BYTE_W-1:0]
      coding_filter_cfg,
   // interrupt, active low
   output logic line_int_n
);
   import lccr_pkg::*;

   // ==========================================================
   // functions
   // lowest enabled channel answers reads of per-channel registers
   function automatic logic [CH_IDX_W-1:0] pick_channel(
      input logic [NUM_CH-1:0] en);
      logic [CH_IDX_W-1:0] sel;
      sel = '0;
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         if (en[c]) begin
            sel = CH_IDX_W'(c);
         end
      end
      return sel;
   endfunction

   // known register index
   function automatic logic in_map(input logic [IDX_W-1:0] idx);
      logic hit;
      hit = 1'b0;
      if (idx == IDX_RT_READ || idx == IDX_RT_CLEAR) begin
         hit = 1'b1;
      end else if (idx == IDX_CH_ENABLE || idx == IDX_GAIN) begin
         hit = 1'b1;
      end else if (idx == IDX_IO_DATA || idx == IDX_DIR_STAT) begin
         hit = 1'b1;
      end else if (idx == IDX_CODING || idx == IDX_MASK) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // real-time byte from settled pin one and pin two levels
   function automatic logic [BYTE_W-1:0] rt_byte(
      input logic [NUM_CH-1:0][NUM_PINS-1:0] pins);
      logic [BYTE_W-1:0] b;
      b = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         b[2*c] = pins[c][0];
         b[2*c+1] = pins[c][1];
      end
      return b;
   endfunction

   // ==========================================================
   // declarations
   logic [NUM_CH-1:0][NUM_PINS-1:0] pin_s1_r;
   logic [NUM_CH-1:0][NUM_PINS-1:0] pin_s2_r;
   logic [NUM_CH-1:0][NUM_PINS-1:0] pin_s3_r;
   logic [NUM_CH-1:0][NUM_PINS-1:0] pin_stable_r;
   logic [NUM_CH-1:0] io_sec_r;
   logic [NUM_CH-1:0] ch_en_r;
   logic [BYTE_W-1:0] mask_r;
   logic [BYTE_W-1:0] rt_prev_r;
   logic [BYTE_W-1:0] rt_now;
   logic int_pend_r;
   logic int_pend_nxt;
   logic [IDX_W-1:0] idx;
   logic word_ok;
   logic setup_phase;
   logic wr_take;
   logic rd_clear;
   logic rt_event;
   logic [CH_IDX_W-1:0] rd_ch;
   logic [BYTE_W-1:0] rd_byte;

   // ==========================================================
   // apb decode
   assign idx = paddr[WORD_LSB +: IDX_W];
   // upper address bits and byte offset must be zero to hit a word
   assign word_ok = (paddr[WORD_LSB-1:0] == '0)
      && (paddr[ADDR_W-1:WORD_LSB+IDX_W] == '0);
   assign setup_phase = psel && !penable;
   // writes land on the access edge, when pready is sampled high
   assign wr_take = psel && penable && pready && pwrite && word_ok;
   // clear happens on the setup edge that registers the read data, so the
   // byte returned is the one the clear acknowledges
   assign rd_clear = setup_phase && !pwrite && word_ok
      && idx == IDX_RT_CLEAR;
   assign rd_ch = pick_channel(ch_en_r);

   // ==========================================================
   // line pin synchronisers
   // three stages; a level counts once the second and third agree
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_s3_r <= '0;
      end else begin
         pin_s1_r <= line_io_pin_in;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   // settled levels, held while the two late stages disagree
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_stable_r <= '0;
      end else begin
         pin_stable_r <= (pin_s2_r & pin_s3_r)
            | (pin_stable_r & (pin_s2_r ^ pin_s3_r));
      end
   end

   // ==========================================================
   // real-time data and interrupt
   assign rt_now = rt_byte(pin_stable_r);
   // a change only counts where its mask bit is clear
   assign rt_event = |((rt_now ^ rt_prev_r) & ~mask_r);

   // set wins over a clear in the same cycle, so no change is lost
   always_comb begin
      int_pend_nxt = int_pend_r;
      if (rd_clear) begin
         int_pend_nxt = 1'b0;
      end
      if (rt_event) begin
         int_pend_nxt = 1'b1;
      end
   end

   // previous byte for change detect, pending flag, pin drive
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rt_prev_r <= RT_RST;
         int_pend_r <= 1'b0;
         line_int_n <= 1'b1;
      end else begin
         rt_prev_r <= rt_now;
         int_pend_r <= int_pend_nxt;
         line_int_n <= !int_pend_r;
      end
   end

   // ==========================================================
   // channel-independent registers
   // mask and channel enables ignore the enables themselves
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask_r <= MASK_RST;
         ch_en_r <= CH_EN_RST;
      end else if (wr_take) begin
         if (idx == IDX_MASK) begin
            mask_r <= pwdata[BYTE_W-1:0];
         end else if (idx == IDX_CH_ENABLE) begin
            ch_en_r <= pwdata[NUM_CH-1:0];
         end
      end
   end

   // ==========================================================
   // per-channel registers
   // a write reaches every enabled channel at once (broadcast)
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         gain_cfg <= {NUM_CH{GAIN_RST}};
         full_loopback <= '0;
         coding_filter_cfg <= {NUM_CH{CODING_RST}};
         line_io_pin_out <= {NUM_CH{IO_DATA_RST}};
         io_sec_r <= '0;
         line_io_pin_oe <= {NUM_CH{DIR_RST}};
      end else if (wr_take) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (ch_en_r[c]) begin
               if (idx == IDX_GAIN) begin
                  gain_cfg[c] <= pwdata[BYTE_W-1:0];
                  full_loopback[c] <=
                     (pwdata[CODE_W-1:0] == CODE_LOOPBACK);
               end else if (idx == IDX_CODING) begin
                  coding_filter_cfg[c] <= pwdata[BYTE_W-1:0];
               end else if (idx == IDX_IO_DATA) begin
                  // every pin latches, direction decides what shows
                  line_io_pin_out[c] <= pwdata[NUM_PINS-1:0];
                  io_sec_r[c] <= pwdata[IO_SEC_PIN_BIT];
               end else if (idx == IDX_DIR_STAT) begin
                  // status bits above are read-only, writes drop them
                  line_io_pin_oe[c] <= pwdata[NUM_PINS-1:0];
               end
            end
         end
      end
   end

   // secondary first-pin bit only reaches the pin in multiplexed mode
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         secondary_first_pin_out <= '0;
      end else begin
         secondary_first_pin_out <=
            io_sec_r & multiplexed_line_mode_enable;
      end
   end

   // ==========================================================
   // read mux
   // per-channel reads show zero when no channel is enabled, except the clock failure bit of the direction/status read
   always_comb begin
      rd_byte = '0;
      if (idx == IDX_RT_READ || idx == IDX_RT_CLEAR) begin
         rd_byte = rt_now;
      end else if (idx == IDX_MASK) begin
         rd_byte = mask_r;
      end else if (idx == IDX_CH_ENABLE) begin
         rd_byte[NUM_CH-1:0] = ch_en_r;
      end else if (idx == IDX_DIR_STAT) begin
         // clock failure shows even with no channel enabled
         rd_byte[STAT_CLOCK_SYNC_FAIL_FLAG_BIT] = clock_sync_fail_in;
         if (ch_en_r != '0) begin
            rd_byte[NUM_PINS-1:0] = line_io_pin_oe[rd_ch];
            rd_byte[STAT_ACTIVE_BIT] = channel_active_in[rd_ch];
         end
      end else if (ch_en_r != '0) begin
         if (idx == IDX_GAIN) begin
            rd_byte = gain_cfg[rd_ch];
         end else if (idx == IDX_CODING) begin
            rd_byte = coding_filter_cfg[rd_ch];
         end else if (idx == IDX_IO_DATA) begin
            // output pins read the latch, input pins their level
            rd_byte[NUM_PINS-1:0] =
               (line_io_pin_out[rd_ch] & line_io_pin_oe[rd_ch])
               | (pin_stable_r[rd_ch] & ~line_io_pin_oe[rd_ch]);
            rd_byte[IO_SEC_PIN_BIT] = io_sec_r[rd_ch];
         end
      end
   end

   // ==========================================================
   // apb answer
   // data and ready are set up on the setup edge, so every access
   // phase is a single cycle with no wait state
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         prdata <= {{(DATA_W-BYTE_W){1'b0}}, rd_byte};
         pready <= 1'b1;
         pslverr <= !(word_ok && in_map(idx));
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule // lccr_regs

// ===== design/lccr_pkg.sv
/*
 lccr_pkg: register indices, field positions, reset values and widths
 for the line channel configuration register bank.
 assumes an APB slave with 32-bit data, one aligned word per register;
 the byte address of each register is four times its index.
*/
package lccr_pkg;
   // ==========================================================
   // sizes
   localparam int NUM_CH = 4;
   localparam int NUM_PINS = 5;
   localparam int IDX_W = 8;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int WORD_LSB = 2;
   localparam int BYTE_W = 8;
   localparam int CODE_W = 5;
   localparam int CH_IDX_W = 2;

   // ==========================================================
   // register indices (byte address = index * 4)
   localparam logic [IDX_W-1:0] IDX_RT_READ = 8'h4d;
   localparam logic [IDX_W-1:0] IDX_RT_CLEAR = 8'h4f;
   localparam logic [IDX_W-1:0] IDX_CH_ENABLE = 8'h4a;
   localparam logic [IDX_W-1:0] IDX_GAIN = 8'h50;
   localparam logic [IDX_W-1:0] IDX_IO_DATA = 8'h52;
   localparam logic [IDX_W-1:0] IDX_DIR_STAT = 8'h54;
   localparam logic [IDX_W-1:0] IDX_CODING = 8'h60;
   localparam logic [IDX_W-1:0] IDX_MASK = 8'h6c;

   // ==========================================================
   // field positions
   localparam int GAIN_ATTEN_DIS_BIT = 7;
   localparam int GAIN_TX_BOOST_BIT = 6;
   localparam int GAIN_RX_LOSS_BIT = 5;
   localparam int IO_SEC_PIN_BIT = 5;
   localparam int STAT_ACTIVE_BIT = 6;
   localparam int STAT_CLOCK_SYNC_FAIL_FLAG_BIT = 5;
   localparam int CODING_LINEAR_BIT = 7;
   localparam int CODING_MULAW_BIT = 6;
   localparam logic [CODE_W-1:0] CODE_LOOPBACK = 5'h10;

   // ==========================================================
   // reset values
   localparam logic [BYTE_W-1:0] GAIN_RST = 8'h00;
   localparam logic [NUM_PINS-1:0] IO_DATA_RST = 5'h00;
   localparam logic [NUM_PINS-1:0] DIR_RST = 5'h00;
   localparam logic [BYTE_W-1:0] CODING_RST = 8'h00;
   localparam logic [BYTE_W-1:0] MASK_RST = 8'hff;
   localparam logic [BYTE_W-1:0] RT_RST = 8'h0f;
   localparam logic [NUM_CH-1:0] CH_EN_RST = 4'hf;
endpackage

// ===== verif/lccr_regs_sva.sv
/*
 lccr_regs_sva: concurrent checks on the apb side, pin direction,
 gain outputs and interrupt of lccr_regs.
 assumes one clock domain and the port names of lccr_regs.
*/
`timescale 1ns/100ps
module lccr_regs_sva (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lccr_pkg::ADDR_W-1:0] paddr,
   input wire logic [lccr_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // watched outputs
   input wire logic [lccr_pkg::NUM_CH-1:0][lccr_pkg::NUM_PINS-1:0]
      line_io_pin_oe,
   input wire logic [lccr_pkg::NUM_CH-1:0][lccr_pkg::BYTE_W-1:0] gain_cfg,
   input wire logic [lccr_pkg::NUM_CH-1:0] full_loopback,
   input wire logic line_int_n
);
   import lccr_pkg::*;
   // ==========================================================
   // helpers
   logic [NUM_CH-1:0] lb_exp;
   logic setup;
   logic wr_done;
   logic clr;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // loopback decode expected from each channel's code
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         lb_exp[c] = gain_cfg[c][CODE_W-1:0] == CODE_LOOPBACK;
      end
   end
   assign setup = psel && !penable;
   assign wr_done = psel && penable && pwrite && pready;
   // clear happens at setup, so the pin may lag two edges
   assign clr = setup && paddr == {2'b00, IDX_RT_CLEAR, 2'b00};
   sequence s_setup;
      setup;
   endsequence
   sequence s_misalign;
      s_setup ##0 (paddr[1:0] != 2'b00);
   endsequence
   a_ready_next: assert property (s_setup |=> pready && penable)
      else $error("pready missing after setup");
   a_ready_access: assert property (pready |-> penable && $past(setup))
      else $error("pready outside access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_err_misalign: assert property (s_misalign |=> pslverr)
      else $error("misaligned access not refused");
   a_rd_upper: assert property (pready |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   a_loopback_decode: assert property (full_loopback == lb_exp)
      else $error("loopback not tied to code");
   a_oe_write_only: assert property (
      $changed(line_io_pin_oe) |-> $past(wr_done))
      else $error("direction changed without write");
   a_gain_write_only: assert property (
      $changed(gain_cfg) |-> $past(wr_done))
      else $error("gain changed without write");
   a_int_hold: assert property (
      !line_int_n && !clr && !$past(clr) |=> !line_int_n)
      else $error("interrupt dropped without clear");
endmodule // lccr_regs_sva

bind lccr_regs lccr_regs_sva lccr_regs_sva_inst (.clock, .rst, .psel,
   .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .line_io_pin_oe,
   .gain_cfg, .full_loopback, .line_int_n);

// ===== verif/lccr_slic_model.sv
/*
 lccr_slic_model: line circuit on the i/o pins; resolves each wire.
 assumes the device drives a pin only while its enable is high.
*/
`timescale 1ns/100ps
module lccr_slic_model (
   // device side
   input wire logic [3:0][4:0] pin_oe,
   input wire logic [3:0][4:0] pin_out,
   // line circuit drive and resolved wire
   input wire logic [3:0][4:0] slic_drive,
   output logic [3:0][4:0] pin_level
);
   // ==========================================================
   // output pins show the latch, the rest follow the line side
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & slic_drive);
endmodule // lccr_slic_model

// ===== verif/line_channel_config_regs_tb_top.sv
/*
 testbench for lccr_regs: apb master tasks, read monitor with queue.
 assumes a 50 ns clock and one-cycle apb answers.
*/
`timescale 1ns/100ps
module line_channel_config_regs_tb_top;
   import lccr_pkg::*;
   // ==========================================================
   // signals
   logic clock, rst, psel, penable, pwrite, pready, pslverr, line_int_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0][4:0] pin_in, pin_out, pin_oe, slic_drive;
   logic [3:0] sec_out, act, mme, lb;
   logic [3:0][7:0] gain, coding;
   logic clock_sync_fail_flag;
   logic [32:0] q[$];
   logic [7:0] v;
   int n_fail = 0, comparisons = 0, seed = 32'h92a9;
   lccr_regs lccr_regs_inst (.clock(clock), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .line_io_pin_in(pin_in), .line_io_pin_out(pin_out),
      .line_io_pin_oe(pin_oe), .secondary_first_pin_out(sec_out),
      .channel_active_in(act), .clock_sync_fail_in(clock_sync_fail_flag),
      .multiplexed_line_mode_enable(mme), .gain_cfg(gain),
      .full_loopback(lb), .coding_filter_cfg(coding),
      .line_int_n(line_int_n));
   lccr_slic_model lccr_slic_model_inst (.pin_oe(pin_oe),
      .pin_out(pin_out), .slic_drive(slic_drive), .pin_level(pin_in));
   initial begin
      clock = 0;
      forever #25 clock = ~clock;
   end
   // ==========================================================
   // tasks
   task automatic summarize();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // bit 32 of a note means only an error answer is expected
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [7:0] d, input logic [32:0] e);
      int n;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      if (!w) q.push_back(e);
      @(posedge clock);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // bound used up with no answer: count it and stop here
      if (pready !== 1'b1) begin
         n_fail++;
         summarize();
      end
      psel <= 0;
      penable <= 0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      apb(1, {2'b00, i, 2'b00}, d, 0);
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] d);
      apb(0, {2'b00, i, 2'b00}, 0, {25'h0, d});
   endtask
   task automatic wint(input logic lv);
      int n;
      for (n = 0; n < 20 && line_int_n !== lv; n++) @(posedge clock);
      chk(line_int_n, lv);
      if (line_int_n !== lv) summarize();
   endtask
   // read monitor takes the oldest note
   always @(posedge clock) begin
      if (psel && penable && pready && !pwrite) begin
         // an answer with no note pending is a mismatch by itself
         if (q.size() == 0) chk(1, 0);
         else if (q[0][32]) chk(pslverr, 1);
         else chk({pslverr, prdata}, q[0]);
         // own discard, so the main sequence keeps v to itself
         if (q.size() != 0) void'(q.pop_front());
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      // reset high from time zero, bus idle
      rst <= 1'b1;
      {psel, penable, pwrite, paddr, pwdata} <= '0;
      {slic_drive, act, mme, clock_sync_fail_flag} <= '0;
      repeat (6) @(posedge clock);
      rst <= 0;
      @(posedge clock);
      rd(IDX_MASK, MASK_RST);
      rd(IDX_GAIN, GAIN_RST);
      rd(IDX_DIR_STAT, 0);
      rd(IDX_CODING, CODING_RST);
      for (int i = 0; i < 5; i++) begin
         v = i < 3 ? 8'($random(seed)) : (i == 3 ? 8'h10 : 8'hf0);
         wr(IDX_GAIN, v);
         rd(IDX_GAIN, v);
         chk(gain[3], v);
         chk(lb, {4{v[4:0] == 5'h10}});
      end
      for (int i = 0; i < 8; i++) begin
         wr(IDX_CODING, 8'h01 << i);
         chk(coding[2], 8'h01 << i);
      end
      rd(IDX_CODING, 8'h80);
      slic_drive[0][0] <= 1;
      slic_drive[3][1] <= 1;
      repeat (10) @(posedge clock);
      chk(line_int_n, 1);
      wr(IDX_MASK, 8'hfe);
      slic_drive[0][0] <= 0;
      wint(0);
      rd(IDX_RT_READ, 8'h80);
      repeat (3) @(posedge clock);
      chk(line_int_n, 0);
      rd(IDX_RT_CLEAR, 8'h80);
      wint(1);
      wr(IDX_CH_ENABLE, 0);
      clock_sync_fail_flag <= 1;
      rd(IDX_RT_READ, 8'h80);
      rd(IDX_MASK, 8'hfe);
      rd(IDX_DIR_STAT, 8'h20);
      wr(IDX_CH_ENABLE, 8'h0f);
      act <= 4'h1;
      wr(IDX_DIR_STAT, 8'h15);
      rd(IDX_DIR_STAT, 8'h75);
      chk(pin_oe[1], 5'h15);
      wr(IDX_IO_DATA, 8'h3f);
      rd(IDX_IO_DATA, 8'h35);
      chk(pin_out[2], 5'h1f);
      chk(sec_out, 0);
      mme <= 4'h6;
      repeat (2) @(posedge clock);
      chk(sec_out, 4'h6);
      apb(0, 12'h000, 0, {1'b1, 32'h0});
      apb(0, 12'h135, 0, {1'b1, 32'h0});
      summarize();
   end
endmodule // line_channel_config_regs_tb_top
